// *** rtl/pss_pkg.sv ***
// pss_pkg: constants, types and decode helpers for the power sequencer
// assumes a 40 MHz system clock; all users refer to names as pss_pkg::name
package pss_pkg;

  // clock rate and timing
  localparam int CLK_HZ = 40000000;
  localparam int PIN_LOW_MIN_MS = 5;
  localparam int PIN_LOW_CYC = (CLK_HZ / 1000) * PIN_LOW_MIN_MS;
  localparam int BOOT_MAX_MS = 300;
  localparam int BOOT_CYC = (CLK_HZ / 1000) * BOOT_MAX_MS;
  localparam logic [4:0] RST_CYC = 5'h10; // core reset pulse length

  // transaction prefixes
  localparam logic [1:0] PFX_READ = 2'h0;
  localparam logic [1:0] PFX_HOSTCMD = 2'h1;
  localparam logic [1:0] PFX_WRITE = 2'h2;
  localparam logic [1:0] PFX_UNDEF = 2'h3;

  // host command opcodes (values arbitrary)
  localparam logic [7:0] CMD_ACTIVE = 8'h40;
  localparam logic [7:0] CMD_STANDBY = 8'h41;
  localparam logic [7:0] CMD_SLEEP = 8'h42;
  localparam logic [7:0] CMD_PWRDOWN = 8'h43;
  localparam logic [7:0] CMD_EXTERNAL_CLOCK_SELECT = 8'h44;
  localparam logic [7:0] CMD_CLKINT = 8'h48;
  localparam logic [7:0] CMD_CLKMUL = 8'h61;
  localparam logic [7:0] CMD_RSTPULSE = 8'h68;
  localparam logic [7:0] CMD_PINSTATE = 8'h70;

  // memory map
  localparam logic [21:0] GRAM_END = 22'h03ffff;
  localparam logic [21:0] FONT_BASE = 22'h2c0000;
  localparam logic [21:0] FONT_END = 22'h2fffff;
  localparam logic [21:0] DLIST_BASE = 22'h300000;
  localparam logic [21:0] DLIST_END = 22'h301fff;
  localparam logic [21:0] REGS_BASE = 22'h302000;
  localparam logic [21:0] REGS_END = 22'h302fff;
  localparam logic [21:0] CMDBUF_BASE = 22'h308000;
  localparam logic [21:0] CMDBUF_END = 22'h308fff;
  localparam logic [21:0] ENG_RST_ADDR = 22'h302020;

  // engine reset control
  localparam logic [2:0] ENG_RST_RESET = 3'h2;
  localparam int ENG_GFX_BIT = 0;
  localparam int ENG_TOUCH_BIT = 1;
  localparam int ENG_AUDIO_BIT = 2;

  // pin groups, two mode bits each; low groups 0..7, float 8..11
  localparam int PIN_GROUPS = 12;
  localparam logic [1:0] PIN_NORMAL = 2'h0;
  localparam logic [1:0] PIN_HOLD = 2'h1;
  localparam logic [1:0] PIN_LOW = 2'h2;
  localparam logic [1:0] PIN_FLOAT = 2'h3;
  localparam logic [23:0] OFF_PIN_DEFAULT = 24'hffaaaa;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_BOOT_CLK = 3'h1,
    ST_BOOT_RAM = 3'h2,
    ST_ACTIVE = 3'h3,
    ST_STANDBY = 3'h4,
    ST_PWRDOWN = 3'h5,
    ST_RESET = 3'h6
  } pss_state_type;

  typedef enum logic [2:0] {
    RGN_GRAM = 3'h0,
    RGN_FONT = 3'h1,
    RGN_DLIST = 3'h2,
    RGN_REGS = 3'h3,
    RGN_CMDBUF = 3'h4,
    RGN_RESERVED = 3'h7
  } pss_rgn_type;

  typedef struct packed {
    logic [1:0] prefix;
    logic [21:0] addr;
  } pss_hdr_type;

  typedef struct packed {
    logic osc_en;
    logic pll_en;
    logic core_clk_en;
    logic core_pwr_en;
  } pss_clk_type;

  typedef struct packed {
    logic valid;
    logic write;
    pss_rgn_type region;
    logic [21:0] addr;
  } pss_acc_type;

  // map a 22-bit address onto its region
  function automatic pss_rgn_type region_of(input logic [21:0] a);
    if (a <= GRAM_END) return RGN_GRAM;
    if (a >= FONT_BASE && a <= FONT_END) return RGN_FONT;
    if (a >= DLIST_BASE && a <= DLIST_END) return RGN_DLIST;
    if (a >= REGS_BASE && a <= REGS_END) return RGN_REGS;
    if (a >= CMDBUF_BASE && a <= CMDBUF_END) return RGN_CMDBUF;
    return RGN_RESERVED;
  endfunction : region_of

endpackage : pss_pkg

// *** rtl/pss_power_seq.sv ***
// pss_power_seq: power state, reset and boot sequencer of the controller
// assumes host pins and pll lock are asynchronous; repair done is on sys_clk
module pss_power_seq #(
  parameter int PIN_LOW_CYC = pss_pkg::PIN_LOW_CYC,
  parameter int BOOT_CYC = pss_pkg::BOOT_CYC
) (
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic chip_off_n,
  // clock generator and ram repair
  input wire logic pll_locked,
  input wire logic ram_repair_done,
  // clock, power and reset controls
  output pss_pkg::pss_clk_type clk_ctrl,
  output logic ext_clock_sel,
  output logic [7:0] clock_mult,
  output logic core_rst_n,
  output logic ram_repair_go,
  output logic boot_timeout,
  // engines and power state
  output logic [2:0] engine_en,
  output logic [2:0] engine_reset_ctrl,
  output pss_pkg::pss_state_type power_state,
  // pin states and access decode
  output logic [23:0] pin_mode,
  output pss_pkg::pss_acc_type access,
  output logic bad_access
);

  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic sck_s, cs_n_s, mosi_s, off_n_s, lock_s;
  logic off_prev_reg;
  logic [23:0] low_cnt_reg;
  logic pin_long_reg;
  pss_pkg::pss_hdr_type hdr;
  logic hdr_stb;
  logic [7:0] data;
  logic data_stb;
  logic [7:0] opcode, param;
  logic cmd_stb;
  logic rst_evt, wake_evt;
  pss_pkg::pss_state_type state_reg;
  logic wake_boot_reg;
  logic boot_pending_reg;
  logic [4:0] rst_cnt_reg;
  logic [23:0] boot_cnt_reg;
  logic eng_wr_pend_reg;
  logic [23:0] off_cfg_reg;
  pss_pkg::pss_clk_type clk_reg;
  logic ext_clk_reg;
  logic [7:0] mult_reg;
  logic core_rst_n_reg;
  logic repair_go_reg;
  logic boot_to_reg;
  logic [2:0] eng_en_reg;
  logic [2:0] eng_rst_reg;
  logic [23:0] pin_mode_reg;
  pss_pkg::pss_acc_type acc_reg;
  logic bad_reg;

  // every output straight from a flop
  assign clk_ctrl = clk_reg;
  assign ext_clock_sel = ext_clk_reg;
  assign clock_mult = mult_reg;
  assign core_rst_n = core_rst_n_reg;
  assign ram_repair_go = repair_go_reg;
  assign boot_timeout = boot_to_reg;
  assign engine_en = eng_en_reg;
  assign engine_reset_ctrl = eng_rst_reg;
  assign power_state = state_reg;
  assign pin_mode = pin_mode_reg;
  assign access = acc_reg;
  assign bad_access = bad_reg;

  // two-stage synchronisers for every asynchronous input
  // reset to the idle pin levels so no false sck edge follows reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= 5'h0a;
      sync_reg <= 5'h0a;
    end else begin
      meta_reg <= {pll_locked, chip_off_n, spi_mosi, spi_cs_n, spi_sck};
      sync_reg <= meta_reg;
    end
  end
  assign sck_s = sync_reg[0];
  assign cs_n_s = sync_reg[1];
  assign mosi_s = sync_reg[2];
  assign off_n_s = sync_reg[3];
  assign lock_s = sync_reg[4];

  pss_spi_rx u_rx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sck_s(sck_s),
    .cs_n_s(cs_n_s),
    .mosi_s(mosi_s),
    .hdr(hdr),
    .hdr_stb(hdr_stb),
    .data(data),
    .data_stb(data_stb)
  );

  // host command opcode and parameter live in the header itself
  assign opcode = {hdr.prefix, hdr.addr[21:16]};
  assign param = hdr.addr[15:8];
  assign cmd_stb = hdr_stb && hdr.prefix == pss_pkg::PFX_HOSTCMD;

  // off pin low time, saturating so a long hold cannot wrap
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      off_prev_reg <= 1'b1;
      low_cnt_reg <= 24'h000000;
      pin_long_reg <= 1'b0;
    end else begin
      off_prev_reg <= off_n_s;
      if (off_n_s) begin
        low_cnt_reg <= 24'h000000;
        pin_long_reg <= 1'b0;
      end else if (low_cnt_reg >= 24'(PIN_LOW_CYC - 1)) begin
        pin_long_reg <= 1'b1;
      end else begin
        low_cnt_reg <= low_cnt_reg + 24'h000001;
      end
    end
  end

  // reset events outside POWERDOWN, and the wake from it
  assign rst_evt = off_n_s && state_reg != pss_pkg::ST_PWRDOWN &&
    ((off_n_s && !off_prev_reg && pin_long_reg) ||
     (cmd_stb && (opcode == pss_pkg::CMD_RSTPULSE ||
                  opcode == pss_pkg::CMD_EXTERNAL_CLOCK_SELECT ||
                  opcode == pss_pkg::CMD_CLKINT)));
  assign wake_evt = state_reg == pss_pkg::ST_PWRDOWN && off_n_s &&
    cmd_stb && opcode == pss_pkg::CMD_ACTIVE;

  // power state machine; the pin overrides every command
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= pss_pkg::ST_SLEEP;
      wake_boot_reg <= 1'b0;
    end else if (!off_n_s) begin
      state_reg <= pss_pkg::ST_PWRDOWN;
    end else if (wake_evt) begin
      state_reg <= pss_pkg::ST_RESET;
      wake_boot_reg <= 1'b1;
    end else if (rst_evt) begin
      state_reg <= pss_pkg::ST_RESET;
      wake_boot_reg <= 1'b0;
    end else begin
      case (state_reg)
        pss_pkg::ST_RESET: begin
          if (rst_cnt_reg == 5'h00) begin
            state_reg <= wake_boot_reg ? pss_pkg::ST_BOOT_CLK
                                       : pss_pkg::ST_SLEEP;
            wake_boot_reg <= 1'b0;
          end
        end
        pss_pkg::ST_SLEEP: begin
          if (cmd_stb && opcode == pss_pkg::CMD_ACTIVE) begin
            state_reg <= pss_pkg::ST_BOOT_CLK;
          end else if (cmd_stb && opcode == pss_pkg::CMD_PWRDOWN) begin
            state_reg <= pss_pkg::ST_PWRDOWN;
          end
        end
        pss_pkg::ST_BOOT_CLK: begin
          if (lock_s) begin
            state_reg <= boot_pending_reg ? pss_pkg::ST_BOOT_RAM
                                          : pss_pkg::ST_ACTIVE;
          end
        end
        pss_pkg::ST_BOOT_RAM: begin
          if (ram_repair_done) begin
            state_reg <= pss_pkg::ST_ACTIVE;
          end
        end
        pss_pkg::ST_ACTIVE, pss_pkg::ST_STANDBY: begin
          if (cmd_stb && opcode == pss_pkg::CMD_STANDBY) begin
            state_reg <= pss_pkg::ST_STANDBY;
          end else if (cmd_stb && opcode == pss_pkg::CMD_SLEEP) begin
            state_reg <= pss_pkg::ST_SLEEP;
          end else if (cmd_stb && opcode == pss_pkg::CMD_PWRDOWN) begin
            state_reg <= pss_pkg::ST_PWRDOWN;
          end else if (cmd_stb && opcode == pss_pkg::CMD_ACTIVE) begin
            state_reg <= pss_pkg::ST_ACTIVE; // no boot from standby
          end
        end
        pss_pkg::ST_PWRDOWN: begin
          state_reg <= pss_pkg::ST_PWRDOWN; // left only by wake_evt
        end
        default: begin
          state_reg <= pss_pkg::ST_RESET;
        end
      endcase
    end
  end

  // core reset pulse after POR and after each reset event
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_cnt_reg <= pss_pkg::RST_CYC;
      core_rst_n_reg <= 1'b0;
    end else begin
      if (off_n_s && (rst_evt || wake_evt)) begin
        rst_cnt_reg <= pss_pkg::RST_CYC;
      end else if (rst_cnt_reg != 5'h00) begin
        rst_cnt_reg <= rst_cnt_reg - 5'h01;
      end
      core_rst_n_reg <= rst_cnt_reg == 5'h00 &&
        state_reg != pss_pkg::ST_RESET;
    end
  end

  // ram repair needed once after every reset; boot time watchdog
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      boot_pending_reg <= 1'b1;
      boot_cnt_reg <= 24'h000000;
      boot_to_reg <= 1'b0;
      repair_go_reg <= 1'b0;
    end else begin
      if (state_reg == pss_pkg::ST_RESET) begin
        boot_pending_reg <= 1'b1;
        boot_to_reg <= 1'b0;
      end else if (state_reg == pss_pkg::ST_BOOT_RAM && ram_repair_done) begin
        boot_pending_reg <= 1'b0;
      end
      repair_go_reg <= state_reg == pss_pkg::ST_BOOT_RAM &&
        !ram_repair_done;
      if (state_reg == pss_pkg::ST_BOOT_CLK ||
          state_reg == pss_pkg::ST_BOOT_RAM) begin
        if (boot_cnt_reg >= 24'(BOOT_CYC - 1)) begin
          boot_to_reg <= 1'b1;
        end else begin
          boot_cnt_reg <= boot_cnt_reg + 24'h000001;
        end
      end else begin
        boot_cnt_reg <= 24'h000000;
      end
    end
  end

  // clock settings; cleared on power-on reset and on wake, kept across other resets
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wake_evt) begin
      ext_clk_reg <= 1'b0;
      mult_reg <= 8'h00;
    end else if (cmd_stb &&
                 opcode == pss_pkg::CMD_EXTERNAL_CLOCK_SELECT) begin
      ext_clk_reg <= 1'b1;
    end else if (cmd_stb && opcode == pss_pkg::CMD_CLKINT) begin
      ext_clk_reg <= 1'b0;
    end else if (cmd_stb && opcode == pss_pkg::CMD_CLKMUL) begin
      mult_reg <= param;
    end
  end

  // power-down pin configuration survives all but power-on reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      off_cfg_reg <= pss_pkg::OFF_PIN_DEFAULT;
    end else if (cmd_stb && opcode == pss_pkg::CMD_PINSTATE &&
                 param[3:0] < 4'(pss_pkg::PIN_GROUPS)) begin
      off_cfg_reg[{param[3:0], 1'b0} +: 2] <= param[5:4];
    end
  end

  // clock and power gating per state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_reg <= '0;
    end else begin
      case (state_reg)
        pss_pkg::ST_ACTIVE: clk_reg <= 4'hf;
        pss_pkg::ST_STANDBY: clk_reg <= 4'hd;
        pss_pkg::ST_BOOT_CLK, pss_pkg::ST_BOOT_RAM: clk_reg <= 4'hd;
        pss_pkg::ST_SLEEP, pss_pkg::ST_RESET: clk_reg <= 4'h1;
        pss_pkg::ST_PWRDOWN: clk_reg <= 4'h0;
        default: clk_reg <= 4'h0;
      endcase
    end
  end

  // engine reset bits, written by a register write while active
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state_reg == pss_pkg::ST_RESET ||
        state_reg == pss_pkg::ST_PWRDOWN) begin
      eng_rst_reg <= pss_pkg::ENG_RST_RESET;
      eng_wr_pend_reg <= 1'b0;
    end else if (hdr_stb) begin
      eng_wr_pend_reg <= hdr.prefix == pss_pkg::PFX_WRITE &&
        hdr.addr == pss_pkg::ENG_RST_ADDR &&
        state_reg == pss_pkg::ST_ACTIVE;
    end else if (data_stb && eng_wr_pend_reg) begin
      eng_rst_reg <= data[2:0];
      eng_wr_pend_reg <= 1'b0;
    end
  end

  // engines only while active and out of their own reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      eng_en_reg <= 3'h0;
    end else begin
      eng_en_reg <= state_reg == pss_pkg::ST_ACTIVE ? ~eng_rst_reg
                                                    : 3'h0;
    end
  end

  // pin modes: hold in standby and sleep, configured set when off
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_mode_reg <= 24'h000000;
    end else begin
      case (state_reg)
        pss_pkg::ST_STANDBY, pss_pkg::ST_SLEEP:
          pin_mode_reg <= {pss_pkg::PIN_GROUPS{pss_pkg::PIN_HOLD}};
        pss_pkg::ST_PWRDOWN: pin_mode_reg <= off_cfg_reg;
        default:
          pin_mode_reg <= {pss_pkg::PIN_GROUPS{pss_pkg::PIN_NORMAL}};
      endcase
    end
  end

  // memory access decode; refused while not active or unmapped
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_reg <= '0;
      bad_reg <= 1'b0;
    end else begin
      acc_reg.valid <= 1'b0;
      bad_reg <= 1'b0;
      if (hdr_stb && hdr.prefix != pss_pkg::PFX_HOSTCMD) begin
        acc_reg.write <= hdr.prefix == pss_pkg::PFX_WRITE;
        acc_reg.region <= pss_pkg::region_of(hdr.addr);
        acc_reg.addr <= hdr.addr;
        if (hdr.prefix == pss_pkg::PFX_UNDEF ||
            pss_pkg::region_of(hdr.addr) == pss_pkg::RGN_RESERVED ||
            state_reg != pss_pkg::ST_ACTIVE) begin
          bad_reg <= 1'b1;
        end else begin
          acc_reg.valid <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wake;
    state_reg == pss_pkg::ST_PWRDOWN && off_n_s && cmd_stb &&
      opcode == pss_pkg::CMD_ACTIVE;
  endsequence
  sequence s_reset_then_boot;
    state_reg == pss_pkg::ST_RESET ##[1:40]
      state_reg == pss_pkg::ST_BOOT_CLK;
  endsequence

  property p_por_core_rst;
    $rose(rst_n) |-> !core_rst_n_reg && state_reg == pss_pkg::ST_SLEEP;
  endproperty
  a_por_core_rst: assert property (p_por_core_rst)
    else $error("core reset or sleep missing after power-on reset");

  property p_engines_idle;
    state_reg != pss_pkg::ST_ACTIVE |=> eng_en_reg == 3'h0;
  endproperty
  a_engines_idle: assert property (p_engines_idle)
    else $error("engine enabled outside active");

  property p_pin_forces_off;
    !off_n_s |=> state_reg == pss_pkg::ST_PWRDOWN;
  endproperty
  a_pin_forces_off: assert property (p_pin_forces_off)
    else $error("off pin did not force power down");

  property p_active_clocks;
    state_reg == pss_pkg::ST_ACTIVE |=> clk_reg == 4'hf;
  endproperty
  a_active_clocks: assert property (p_active_clocks)
    else $error("clocks not all running in active");

  property p_sleep_clocks;
    state_reg == pss_pkg::ST_SLEEP |=> !clk_reg.osc_en && !clk_reg.pll_en;
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks)
    else $error("oscillator running in sleep");

  property p_off_clocks;
    state_reg == pss_pkg::ST_PWRDOWN |=> clk_reg == 4'h0 &&
      pin_mode_reg == $past(off_cfg_reg);
  endproperty
  a_off_clocks: assert property (p_off_clocks)
    else $error("power down clocks or pins wrong");

  property p_wake_boot;
    s_wake |=> s_reset_then_boot;
  endproperty
  a_wake_boot: assert property (p_wake_boot)
    else $error("wake did not reset and boot");

  property p_wake_clears;
    s_wake |=> !ext_clk_reg && mult_reg == 8'h00;
  endproperty
  a_wake_clears: assert property (p_wake_clears)
    else $error("clock settings survived wake");

  property p_pulse_reset;
    cmd_stb && opcode == pss_pkg::CMD_RSTPULSE && off_n_s &&
      state_reg == pss_pkg::ST_SLEEP |=>
      state_reg == pss_pkg::ST_RESET ##1 !core_rst_n_reg;
  endproperty
  a_pulse_reset: assert property (p_pulse_reset)
    else $error("pulse reset command ignored");

  property p_undef_prefix;
    hdr_stb && hdr.prefix == pss_pkg::PFX_UNDEF |=> bad_reg && !acc_reg.valid;
  endproperty
  a_undef_prefix: assert property (p_undef_prefix)
    else $error("undefined prefix accepted");

  property p_eng_rst_default;
    $rose(rst_n) |-> eng_rst_reg == pss_pkg::ENG_RST_RESET;
  endproperty
  a_eng_rst_default: assert property (p_eng_rst_default)
    else $error("engine reset control default wrong");

endmodule : pss_power_seq

// *** rtl/pss_spi_rx.sv ***
// pss_spi_rx: serial receiver for host transactions, mode 0
// assumes sck, cs_n and mosi already pass a two-stage synchroniser
module pss_spi_rx (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // synchronised serial pins
  input wire logic sck_s,
  input wire logic cs_n_s,
  input wire logic mosi_s,
  // decoded header and data bytes
  output pss_pkg::pss_hdr_type hdr,
  output logic hdr_stb,
  output logic [7:0] data,
  output logic data_stb
);

  logic sck_prev_reg;
  logic [23:0] shift_reg;
  logic [4:0] cnt_reg;
  logic hdr_done_reg;
  logic sck_rise;
  logic [23:0] shift_next;

  assign sck_rise = sck_s & ~sck_prev_reg;
  assign shift_next = {shift_reg[22:0], mosi_s};

  // edge history of the serial clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
    end
  end

  // 24 header bits first, then whole data bytes
  always_ff @(posedge sys_clk) begin
    hdr_stb <= 1'b0;
    data_stb <= 1'b0;
    if (!rst_n) begin
      shift_reg <= 24'h000000;
      cnt_reg <= 5'h00;
      hdr_done_reg <= 1'b0;
      hdr <= '0;
      data <= 8'h00;
    end else if (cs_n_s) begin
      cnt_reg <= 5'h00; // partial bytes are dropped at deselect
      hdr_done_reg <= 1'b0;
    end else if (sck_rise) begin
      shift_reg <= shift_next;
      if (!hdr_done_reg) begin
        if (cnt_reg == 5'h17) begin
          hdr <= shift_next;
          hdr_stb <= 1'b1;
          hdr_done_reg <= 1'b1;
          cnt_reg <= 5'h00;
        end else begin
          cnt_reg <= cnt_reg + 5'h01;
        end
      end else if (cnt_reg == 5'h07) begin
        data <= shift_next[7:0];
        data_stb <= 1'b1;
        cnt_reg <= 5'h00;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

endmodule : pss_spi_rx

// *** sim/pss_host.sv ***
// pss_host: host model, mode 0 serial master plus off pin
// assumes sck idles low and stands still between frames
module pss_host (
  // host pins
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  output logic chip_off_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    chip_off_n = 1'b1;
  end
  // msb first, 200 ns bit time, data byte only when dv
  task automatic xfer(input logic [23:0] h, input bit dv,
    input logic [7:0] d);
    logic [31:0] w;
    w = {h, d};
    spi_cs_n <= 1'b0;
    for (int i = 31; i >= (dv ? 0 : 8); i--) begin
      spi_mosi <= w[i];
      #100 spi_sck <= 1'b1;
      #100 spi_sck <= 1'b0;
    end
    #100 spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // released line must not show stale data
    #200;
  endtask : xfer
  // off pin level; the bench owns the hold time
  task automatic pin(input logic v);
    chip_off_n <= v;
  endtask : pin
endmodule : pss_host

// *** sim/pss_power_seq_bench.sv ***
// pss_power_seq_bench: self-checking bench of the power sequencer
// assumes pss_host on the pins; long counts shortened by parameters
module pss_power_seq_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PLC = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pll_locked = 1'b0;
  logic ram_repair_done = 1'b0;
  logic spi_sck, spi_cs_n, spi_mosi, chip_off_n;
  logic ext_clock_sel, core_rst_n, ram_repair_go, boot_timeout, bad_access;
  logic [7:0] clock_mult;
  logic [2:0] engine_en, engine_reset_ctrl;
  logic [23:0] pin_mode;
  pss_pkg::pss_clk_type clk_ctrl;
  pss_pkg::pss_state_type power_state;
  pss_pkg::pss_acc_type access;
  logic [4:0] exp_q[$];
  bit act = 1'b0;
  logic [21:0] bases[8] = '{22'h0, 22'h3f000, 22'h40000, 22'h2c0000,
    22'h2ff000, 22'h302000, 22'h303000, 22'h308000};
  logic [1:0] pfx[3] = '{2'h0, 2'h2, 2'h3};
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  pss_host i_pss_host (.spi_sck, .spi_cs_n, .spi_mosi, .chip_off_n);
  pss_power_seq #(.PIN_LOW_CYC(PLC), .BOOT_CYC(200)) i_pss_power_seq (
    .sys_clk, .rst_n, .spi_sck, .spi_cs_n, .spi_mosi, .chip_off_n,
    .pll_locked, .ram_repair_done, .clk_ctrl, .ext_clock_sel, .clock_mult,
    .core_rst_n, .ram_repair_go, .boot_timeout, .engine_en,
    .engine_reset_ctrl, .power_state, .pin_mode, .access, .bad_access);
  // lock trails pll enable; repair answers a cycle after its request
  always @(posedge sys_clk) begin
    pll_locked <= clk_ctrl.pll_en;
    ram_repair_done <= ram_repair_go;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic check(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check
  // each access result takes the oldest note, refusal as 5'h10
  always @(posedge sys_clk) begin
    if (access.valid === 1'b1 || bad_access === 1'b1) begin
      check("access", bad_access ? 5'h10 :
        {1'b0, access.write, access.region},
        exp_q.pop_front());
    end
  end
  // expected region from the map, state from what the bench commanded
  function automatic logic [4:0] exp_of(logic [1:0] p, logic [21:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a < 22'h40000) r = 3'h0;
    else if (a >= 22'h2c0000 && a < 22'h300000) r = 3'h1;
    else if (a >= 22'h300000 && a < 22'h302000) r = 3'h2;
    else if (a >= 22'h302000 && a < 22'h303000) r = 3'h3;
    else if (a >= 22'h308000 && a < 22'h309000) r = 3'h4;
    if (p[0] || !act || r == 3'h7) return 5'h10;
    return {1'b0, p[1], r};
  endfunction : exp_of
  task automatic acc(input logic [1:0] p, input logic [21:0] a);
    exp_q.push_back(exp_of(p, a));
    i_pss_host.xfer({p, a}, 1'b0, 8'h00);
  endtask : acc
  task automatic cmd(input logic [7:0] op, input logic [7:0] par);
    i_pss_host.xfer({op, par, 8'h00}, 1'b0, 8'h00);
  endtask : cmd
  task automatic wait_st(input pss_pkg::pss_state_type s);
    for (int i = 0; i < 400 && power_state !== s; i++) @(negedge sys_clk);
    @(negedge sys_clk); // derived outputs follow the state one edge later
    check("state", power_state, s);
  endtask : wait_st
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    void'($urandom(32'hd499531c));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
    check("state", power_state, pss_pkg::ST_SLEEP);
    check("rst", {core_rst_n, engine_reset_ctrl}, 4'ha);
    check("clk", clk_ctrl[3:1], 3'h0);
    acc(2'h0, 22'h0);
    cmd(pss_pkg::CMD_EXTERNAL_CLOCK_SELECT, 8'h00);
    wait_st(pss_pkg::ST_SLEEP);
    check("ext", ext_clock_sel, 1'b1);
    cmd(pss_pkg::CMD_CLKINT, 8'h00);
    wait_st(pss_pkg::ST_SLEEP);
    check("ext", ext_clock_sel, 1'b0);
    cmd(pss_pkg::CMD_EXTERNAL_CLOCK_SELECT, 8'h00);
    wait_st(pss_pkg::ST_SLEEP);
    cmd(pss_pkg::CMD_CLKMUL, 8'($urandom));
    cmd(pss_pkg::CMD_RSTPULSE, 8'h00);
    wait_st(pss_pkg::ST_SLEEP);
    cmd(pss_pkg::CMD_ACTIVE, 8'h00);
    wait_st(pss_pkg::ST_ACTIVE);
    act = 1'b1;
    repeat (2) @(posedge sys_clk);
    check("run", {clk_ctrl, boot_timeout, engine_en}, 8'hf5);
    // every prefix but host command against every area but the display list, and its edges
    for (int i = 0; i < 24; i++) begin
      acc(pfx[i % 3], bases[i % 8] + (i[3] ? 22'hfff : $urandom % 4096));
    end
    exp_q.push_back(5'h0b);
    i_pss_host.xfer({2'h2, pss_pkg::ENG_RST_ADDR}, 1'b1, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("eng", {engine_reset_ctrl, engine_en}, 6'h07);
    cmd(pss_pkg::CMD_STANDBY, 8'h00);
    wait_st(pss_pkg::ST_STANDBY);
    check("stby", {clk_ctrl[3:1], engine_en, pin_mode},
      30'h30555555);
    cmd(pss_pkg::CMD_ACTIVE, 8'h00);
    wait_st(pss_pkg::ST_ACTIVE);
    acc(2'h2, 22'h301fff);
    acc(2'h0, 22'h300000);
    cmd(pss_pkg::CMD_SLEEP, 8'h00);
    wait_st(pss_pkg::ST_SLEEP);
    check("slp", {clk_ctrl[3:1], engine_en, pin_mode},
      30'h00555555);
    cmd(pss_pkg::CMD_PINSTATE, 8'h30);
    cmd(pss_pkg::CMD_CLKMUL, 8'h5a);
    check("mult", clock_mult, 8'h5a);
    i_pss_host.pin(1'b0);
    cmd(pss_pkg::CMD_ACTIVE, 8'h00);
    wait_st(pss_pkg::ST_PWRDOWN);
    check("off", {clk_ctrl, pin_mode}, 28'h0ffaaab);
    repeat (PLC + 5) @(posedge sys_clk);
    i_pss_host.pin(1'b1);
    repeat (10) @(posedge sys_clk);
    check("state", power_state, pss_pkg::ST_PWRDOWN);
    cmd(pss_pkg::CMD_ACTIVE, 8'h00);
    wait_st(pss_pkg::ST_RESET);
    check("core_rst", core_rst_n, 1'b0);
    wait_st(pss_pkg::ST_ACTIVE);
    check("clr", {ext_clock_sel, engine_reset_ctrl, clock_mult},
      12'h200);
    cmd(pss_pkg::CMD_PWRDOWN, 8'h00);
    wait_st(pss_pkg::ST_PWRDOWN);
    check("pins", pin_mode, 24'hffaaab);
    check("pending", exp_q.size(), 24'h0);
    stop_test();
  end
endmodule : pss_power_seq_bench
